/* File: logic/uart_consts.vh */
`ifndef UART_CONSTS_VH
`define UART_CONSTS_VH
// Register byte offsets
`define OFS_MODE 4'h0
`define OFS_STAT 4'h4
`define OFS_TXREG 4'h8
`define OFS_RXREG 4'hc
`define OFS_BRG 5'h10
// Mode register fields
`define MODE_EN 15
`define MODE_ALT 10
`define MODE_DATA_PARITY_SELECT_HI 2
`define MODE_DATA_PARITY_SELECT_LO 1
`define MODE_STOP_BIT_SELECT 0
// Status register fields
`define STA_TXISEL 15
`define STA_BRK 11
`define STA_TXEN 10
`define STA_TXBF 9
`define STA_TX_SHIFT_EMPTY 8
`define STA_RXISEL_HI 7
`define STA_RXISEL_LO 6
`define STA_ADDRESS_DETECT_ENABLE 5
`define STA_RECEIVER_IDLE 4
`define STA_PARITY_ERROR 3
`define STA_FRAMING_ERROR 2
`define STA_OVERRUN_ERROR 1
`define STA_RXDA 0
// Status bits that software may write
`define STA_WMASK 16'h8ce2
// Data/parity select codes
`define PD_8N 2'h0
`define PD_8E 2'h1
`define PD_8O 2'h2
`define PD_9N 2'h3
// Reset values
`define MODE_RST 16'h0000
`define BRG_RST 16'h0000
// AHB transfer type
`define HTRANS_NONSEQ 2'h2
`endif

/* File: logic/uart_core.v */
// Added by the designer: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module uart_core #(
  parameter DEPTH = 4,
  parameter PW = 2
) (
  input wire sys_clk,
  input wire srst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire port_tx_lat,
  input wire port_tx_dir_in,
  input wire port_rx_lat,
  input wire port_rx_dir_in,
  input wire port_atx_lat,
  input wire port_atx_dir_in,
  input wire port_arx_lat,
  input wire port_arx_dir_in,
  output reg serial_tx_pin_o,
  output reg serial_tx_pin_oe,
  output reg serial_rx_pin_o,
  output reg serial_rx_pin_oe,
  output reg alternate_tx_pin_o,
  output reg alternate_tx_pin_oe,
  output reg alternate_rx_pin_o,
  output reg alternate_rx_pin_oe,
  input wire serial_rx_pin_i,
  input wire alternate_rx_pin_i,
  input wire [8:0] rx_word_in,
  input wire rx_word_valid,
  input wire rx_word_framing_error,
  input wire rx_word_parity_error,
  input wire rx_busy,
  output wire rx_line,
  output reg tx_event
);
`include "uart_consts.vh"

  // ==========================================================
  // Registers
  // ==========================================================
  reg [15:0] mode_q;
  reg [15:0] brg_q;
  reg tx_isel_q;
  reg brk_q;
  reg txen_q;
  reg [1:0] rx_isel_q;
  reg address_detect_enable_q;
  reg overrun_error_q;
  reg [8:0] txf_q [0:DEPTH-1];
  reg [PW:0] txcnt_q;
  reg [PW-1:0] txrd_q;
  reg [PW-1:0] txwr_q;
  reg [10:0] rxf_q [0:DEPTH-1];
  reg [PW:0] rxcnt_q;
  reg [PW-1:0] rxrd_q;
  reg [PW-1:0] rxwr_q;
  reg [15:0] baud_q;
  reg [11:0] sh_q;
  reg [3:0] nbits_q;
  reg busy_q;
  reg ap_wr_q;
  reg ap_rd_q;
  reg [4:0] ap_addr_q;

  wire en = mode_q[`MODE_EN];
  wire [1:0] data_parity_select = mode_q[`MODE_DATA_PARITY_SELECT_HI:`MODE_DATA_PARITY_SELECT_LO];
  wire two_stop = mode_q[`MODE_STOP_BIT_SELECT];
  wire txbf = (txcnt_q == DEPTH);
  wire tx_shift_empty = ~busy_q;
  wire rxda = (rxcnt_q != 0);
  wire tx_line = brk_q ? 1'b0 : (busy_q ? sh_q[0] : 1'b1);

  // Parity bit for an 8-bit character
  function par_bit;
    input [7:0] d;
    input [1:0] sel;
    begin
      par_bit = (sel == `PD_8O) ? ~^d : ^d;
    end
  endfunction

  // ==========================================================
  // AHB-Lite slave, zero wait states
  // ==========================================================
  wire ap_take = hsel & hready & (htrans == `HTRANS_NONSEQ);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Address phase capture
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      ap_wr_q <= 1'b0;
      ap_rd_q <= 1'b0;
      ap_addr_q <= 5'h00;
    end
    else
    begin
      ap_wr_q <= ap_take & hwrite;
      ap_rd_q <= ap_take & ~hwrite;
      ap_addr_q <= haddr[4:0];
    end
  end

  wire wr_mode = ap_wr_q & (ap_addr_q == {1'b0, `OFS_MODE});
  wire wr_stat = ap_wr_q & (ap_addr_q == {1'b0, `OFS_STAT});
  wire wr_tx = ap_wr_q & (ap_addr_q == {1'b0, `OFS_TXREG});
  wire wr_brg = ap_wr_q & (ap_addr_q == `OFS_BRG);
  wire rd_rx = ap_rd_q & (ap_addr_q == {1'b0, `OFS_RXREG});
  wire going_off = wr_mode & ~hwdata[`MODE_EN] & en;

  // Status word as read
  wire [15:0] stat_w = {tx_isel_q, 3'h0, brk_q, txen_q, txbf, tx_shift_empty,
    rx_isel_q, address_detect_enable_q, ~rx_busy, rxda & rxf_q[rxrd_q][10],
    rxda & rxf_q[rxrd_q][9], overrun_error_q, rxda};

  // Read data, driven in data phase; unmapped reads zero
  always @*
  begin
    hrdata = 32'h00000000;
    if (ap_rd_q)
    begin
      case (ap_addr_q)
        {1'b0, `OFS_MODE}: hrdata = {16'h0000, mode_q};
        {1'b0, `OFS_STAT}: hrdata = {16'h0000, stat_w};
        {1'b0, `OFS_RXREG}: hrdata = {23'h000000, rxf_q[rxrd_q][8:0]};
        `OFS_BRG: hrdata = {16'h0000, brg_q};
        default: hrdata = 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // Configuration and control bits
  // ==========================================================
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      mode_q <= `MODE_RST;
      brg_q <= `BRG_RST;
      tx_isel_q <= 1'b0;
      rx_isel_q <= 2'h0;
      address_detect_enable_q <= 1'b0;
      txen_q <= 1'b0;
      brk_q <= 1'b0;
    end
    else
    begin
      if (wr_mode)
        mode_q <= hwdata[15:0];
      if (wr_brg)
        brg_q <= hwdata[15:0];
      if (wr_stat)
      begin
        tx_isel_q <= hwdata[`STA_TXISEL];
        rx_isel_q <= hwdata[`STA_RXISEL_HI:`STA_RXISEL_LO];
        address_detect_enable_q <= hwdata[`STA_ADDRESS_DETECT_ENABLE];
      end
      // Selects kept across disable
      if (~en | going_off)
      begin
        txen_q <= 1'b0;
        brk_q <= 1'b0;
      end
      else if (wr_stat)
      begin
        txen_q <= hwdata[`STA_TXEN];
        brk_q <= hwdata[`STA_BRK];
      end
    end
  end

  // ==========================================================
  // Baud generator: tick every brg+1 cycles
  // ==========================================================
  wire run = en & txen_q;
  wire baud_tick = run & (baud_q == 16'h0000);
  always @(posedge sys_clk)
  begin
    if (srst | ~run)
      baud_q <= 16'h0000;
    else if (baud_q == 16'h0000)
      baud_q <= brg_q;
    else
      baud_q <= baud_q - 16'h0001;
  end

  // ==========================================================
  // Transmit buffer and shifter
  // ==========================================================
  wire tx_push = wr_tx & en & ~txbf;
  wire load = run & ~busy_q & ~brk_q & (txcnt_q != 0) & baud_tick;
  wire [8:0] head = txf_q[txrd_q];
  wire [8:0] wdata = (data_parity_select == `PD_9N) ? hwdata[8:0] : {1'b0, hwdata[7:0]};

  always @(posedge sys_clk)
  begin
    if (tx_push)
      txf_q[txwr_q] <= wdata;
  end

  always @(posedge sys_clk)
  begin
    if (srst | ~en)
    begin
      txcnt_q <= {(PW+1){1'b0}};
      txrd_q <= {PW{1'b0}};
      txwr_q <= {PW{1'b0}};
      busy_q <= 1'b0;
      sh_q <= 12'hfff;
      nbits_q <= 4'h0;
      tx_event <= 1'b0;
    end
    else
    begin
      tx_event <= 1'b0;
      if (tx_push)
        txwr_q <= txwr_q + 1'b1;
      if (load)
        txrd_q <= txrd_q + 1'b1;
      txcnt_q <= txcnt_q + {{PW{1'b0}}, tx_push} - {{PW{1'b0}}, load};
      if (load)
      begin
        busy_q <= 1'b1;
        tx_event <= ~tx_isel_q | (txcnt_q == 1 && !tx_push);
        nbits_q <= 4'd10 + {3'h0, (data_parity_select != `PD_8N)} + {3'h0, two_stop};
        if (data_parity_select == `PD_9N)
          sh_q <= {2'h3, head, 1'b0};
        else if (data_parity_select == `PD_8N)
          sh_q <= {3'h7, head[7:0], 1'b0};
        else
          sh_q <= {2'h3, par_bit(head[7:0], data_parity_select), head[7:0], 1'b0};
      end
      else if (busy_q & baud_tick)
      begin
        sh_q <= {1'b1, sh_q[11:1]};
        nbits_q <= nbits_q - 4'h1;
        if (nbits_q == 4'h1)
          busy_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Receive buffer fed by the receive shifter
  // ==========================================================
  wire rx_push = en & rx_word_valid & (rxcnt_q != DEPTH) & ~overrun_error_q;
  wire rx_pop = rd_rx & rxda;

  always @(posedge sys_clk)
  begin
    if (rx_push)
      rxf_q[rxwr_q] <= {rx_word_parity_error, rx_word_framing_error, rx_word_in};
  end

  always @(posedge sys_clk)
  begin
    if (srst | ~en)
    begin
      rxcnt_q <= {(PW+1){1'b0}};
      rxrd_q <= {PW{1'b0}};
      rxwr_q <= {PW{1'b0}};
      overrun_error_q <= 1'b0;
    end
    else
    begin
      if (rx_push)
        rxwr_q <= rxwr_q + 1'b1;
      if (rx_pop)
        rxrd_q <= rxrd_q + 1'b1;
      rxcnt_q <= rxcnt_q + {{PW{1'b0}}, rx_push} - {{PW{1'b0}}, rx_pop};
      // Overrun set wins over software clear
      if (rx_word_valid & (rxcnt_q == DEPTH))
        overrun_error_q <= 1'b1;
      else if (wr_stat & ~hwdata[`STA_OVERRUN_ERROR])
        overrun_error_q <= 1'b0;
    end
  end

  // ==========================================================
  // Pin steering
  // ==========================================================
  wire alt = mode_q[`MODE_ALT];
  assign rx_line = alt ? alternate_rx_pin_i : serial_rx_pin_i;

  always @*
  begin
    serial_tx_pin_o = port_tx_lat;
    serial_tx_pin_oe = ~port_tx_dir_in;
    serial_rx_pin_o = port_rx_lat;
    serial_rx_pin_oe = ~port_rx_dir_in;
    alternate_tx_pin_o = port_atx_lat;
    alternate_tx_pin_oe = ~port_atx_dir_in;
    alternate_rx_pin_o = port_arx_lat;
    alternate_rx_pin_oe = ~port_arx_dir_in;
    if (en & ~alt)
    begin
      serial_tx_pin_o = tx_line;
      serial_tx_pin_oe = 1'b1;
      serial_rx_pin_o = 1'b0;
      serial_rx_pin_oe = 1'b0;
    end
    else if (en)
    begin
      alternate_tx_pin_o = tx_line;
      alternate_tx_pin_oe = 1'b1;
      alternate_rx_pin_o = 1'b0;
      alternate_rx_pin_oe = 1'b0;
    end
  end

endmodule // uart_core

/* File: verification/uart_core_chk.sv */
`timescale 1ns/1ps
// ====
// Pin routing and event checks
module uart_core_chk (
  input wire sys_clk,
  input wire srst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire port_tx_lat,
  input wire port_tx_dir_in,
  input wire serial_tx_pin_o,
  input wire serial_tx_pin_oe,
  input wire serial_rx_pin_oe,
  input wire alternate_tx_pin_oe,
  input wire alternate_rx_pin_oe,
  input wire serial_rx_pin_i,
  input wire alternate_rx_pin_i,
  input wire rx_line,
  input wire tx_event
);
  reg wr_q;
  reg en_q;
  reg alt_q;
  reg [4:0] a_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence s_quiet;
    !tx_event [*8];
  endsequence
  // Shadow of enable and pin select
  always @(posedge sys_clk)
  begin
    wr_q <= ~srst & hsel & hready & hwrite & (htrans == 2'h2);
    a_q <= haddr[4:0];
    if (srst)
      en_q <= 1'b0;
    else if (wr_q && a_q == 5'h00)
      en_q <= hwdata[15];
    if (wr_q && a_q == 5'h00)
      alt_q <= hwdata[10];
  end
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not okay");
  a_pri_dir: assert property (
    en_q && !alt_q |-> serial_tx_pin_oe && !serial_rx_pin_oe)
    else $error("primary pins not owned");
  a_alt_dir: assert property (
    en_q && alt_q |-> alternate_tx_pin_oe && !alternate_rx_pin_oe)
    else $error("alternate pins not owned");
  a_off_port: assert property (
    !en_q |-> serial_tx_pin_o == port_tx_lat
      && serial_tx_pin_oe == !port_tx_dir_in)
    else $error("disabled pin not port driven");
  a_rx_route: assert property (
    en_q |-> rx_line == (alt_q ? alternate_rx_pin_i : serial_rx_pin_i))
    else $error("receive line wrongly routed");
  a_event_gap: assert property (tx_event |=> s_quiet)
    else $error("transmit events too close");
  a_start_low: assert property (
    $rose(tx_event) && en_q && !alt_q |-> !serial_tx_pin_o)
    else $error("no start bit at load");
  a_off_quiet: assert property (
    !en_q && !$past(en_q) |-> !tx_event)
    else $error("event while disabled");
endmodule // uart_core_chk

bind uart_core uart_core_chk i_uart_core_chk (.sys_clk, .srst, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .port_tx_lat,
  .port_tx_dir_in, .serial_tx_pin_o, .serial_tx_pin_oe, .serial_rx_pin_oe,
  .alternate_tx_pin_oe, .alternate_rx_pin_oe, .serial_rx_pin_i,
  .alternate_rx_pin_i, .rx_line, .tx_event);

/* File: verification/serial_peer.sv */
`timescale 1ns/1ps
// ====
// Remote serial receiver
module serial_peer (
  input wire sys_clk,
  input wire line,
  input wire [31:0] bit_cyc,
  input wire [31:0] nbits,
  input wire two_stop,
  output reg [8:0] got,
  output reg stop_ok,
  output reg [31:0] frames
);
  integer i;
  // Frame decode, sampled mid-bit
  initial
  begin
    frames = 0;
    got = 9'h000;
    stop_ok = 1'b0;
    forever
    begin
      @(negedge line);
      repeat (bit_cyc / 2) @(posedge sys_clk);
      got = 9'h000;
      for (i = 0; i < nbits; i = i + 1)
      begin
        repeat (bit_cyc) @(posedge sys_clk);
        got[i] = line;
      end
      repeat (bit_cyc) @(posedge sys_clk);
      stop_ok = line;
      if (two_stop)
      begin
        repeat (bit_cyc) @(posedge sys_clk);
        stop_ok = stop_ok & line;
      end
      frames = frames + 1;
    end
  end
endmodule // serial_peer

/* File: verification/async_serial_setup_transmit_tb_top.sv */
`timescale 1ns/1ps
`include "uart_consts.vh"
// ====
// Bench top
module async_serial_setup_transmit_tb_top;
  localparam int BRG = 3;
  reg sys_clk, srst, hsel, hwrite, alt, two;
  reg [31:0] haddr, hwdata, rd_q, rd, nb;
  reg [1:0] htrans, pd;
  reg [2:0] hsize;
  reg [8:0] d;
  reg [8:0] rxw;
  reg rxv;
  reg port_tx_lat, port_tx_dir_in, port_rx_lat, port_rx_dir_in;
  reg port_atx_lat, port_atx_dir_in, port_arx_lat, port_arx_dir_in;
  reg serial_rx_pin_i, alternate_rx_pin_i;
  wire hreadyout, hresp, serial_tx_pin_o, serial_tx_pin_oe;
  wire serial_rx_pin_o, serial_rx_pin_oe, alternate_tx_pin_o;
  wire alternate_tx_pin_oe, alternate_rx_pin_o, alternate_rx_pin_oe;
  wire rx_line, tx_event, stop_ok;
  wire [31:0] hrdata, frames;
  wire [8:0] got;
  wire hready = hreadyout;
  wire tx_w = alt ? alternate_tx_pin_o : serial_tx_pin_o;
  integer err_total, n_tests, ev, i, j, s;
  int exp_q [$];
  uart_core i_uart_core (.sys_clk, .srst, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
    .port_tx_lat, .port_tx_dir_in, .port_rx_lat, .port_rx_dir_in,
    .port_atx_lat, .port_atx_dir_in, .port_arx_lat, .port_arx_dir_in,
    .serial_tx_pin_o, .serial_tx_pin_oe, .serial_rx_pin_o,
    .serial_rx_pin_oe, .alternate_tx_pin_o, .alternate_tx_pin_oe,
    .alternate_rx_pin_o, .alternate_rx_pin_oe, .serial_rx_pin_i,
    .alternate_rx_pin_i, .rx_word_in(rxw), .rx_word_valid(rxv),
    .rx_word_framing_error(1'b0), .rx_word_parity_error(1'b0), .rx_busy(1'b0), .rx_line,
    .tx_event);
  serial_peer i_serial_peer (.sys_clk, .line(tx_w), .bit_cyc(BRG + 1),
    .nbits(nb), .two_stop(two), .got, .stop_ok, .frames);
  // Clock
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Read capture, event count, random pin levels
  always @(posedge sys_clk)
  begin
    rd_q <= hrdata;
    ev <= ev + tx_event;
    {port_tx_dir_in, port_rx_lat, port_rx_dir_in, port_atx_dir_in,
      port_arx_lat, port_arx_dir_in, serial_rx_pin_i,
      alternate_rx_pin_i} <= $urandom;
  end
  task chk(input string nm, input [31:0] sn, ex);
  begin
    n_tests = n_tests + 1;
    if (sn !== ex)
    begin
      err_total = err_total + 1;
      $display("[FAIL] %s exp %h seen %h", nm, ex, sn);
    end
  end
  endtask
  task bus(input w, input [31:0] a, dt);
  begin
    hsel <= 1'b1;
    haddr <= a;
    htrans <= `HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= dt;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    #1 rd = rd_q;
  end
  endtask
  // Expected line bits for the current format
  function [8:0] pk(input [8:0] v);
    case (pd)
      `PD_8N: pk = {1'b0, v[7:0]};
      `PD_8E: pk = {^v[7:0], v[7:0]};
      `PD_8O: pk = {~^v[7:0], v[7:0]};
      default: pk = v;
    endcase
  endfunction
  task send(input [8:0] v, input ok);
  begin
    bus(1, `OFS_TXREG, v);
    if (ok)
      exp_q.push_back({1'b1, pk(v)});
  end
  endtask
  task drain;
  begin
    i = 0;
    while (exp_q.size() > 0 && i < 3000)
    begin
      @(posedge sys_clk);
      i = i + 1;
    end
    chk("drained", exp_q.size(), 0);
  end
  endtask
  // Each decoded frame against the model, while an expected frame is queued
  always @(frames)
    if (exp_q.size() > 0)
      chk("frame", {stop_ok, got}, exp_q.pop_front());
  task results;
  begin
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_total = err_total + 1;
    results;
  end
  // Main sequence
  initial
  begin
    {srst, hsel, hwrite, alt, two, haddr, hwdata, htrans} = 71'h1 << 70;
    {pd, nb, ev, err_total, n_tests} = 0;
    rxw = 9'h000;
    rxv = 1'b0;
    port_tx_lat = 1'b1;
    port_atx_lat = 1'b1;
    hsize = 3'h2;
    {port_tx_dir_in, port_rx_lat, port_rx_dir_in, port_atx_dir_in} = 4'h0;
    {port_arx_lat, port_arx_dir_in, serial_rx_pin_i} = 3'h0;
    alternate_rx_pin_i = 1'b0;
    i = $urandom(32'hd83f8318);
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    bus(0, `OFS_MODE, 0);
    chk("mode", rd, `MODE_RST);
    bus(0, `OFS_STAT, 0);
    chk("stat", rd, 32'h110);
    bus(0, 32'h14, 0);
    chk("unmapped", rd, 0);
    bus(1, `OFS_BRG, 32'hffff);
    bus(0, `OFS_BRG, 0);
    chk("brg", rd, 32'hffff);
    bus(1, `OFS_BRG, BRG);
    bus(1, `OFS_MODE, 32'h8000);
    d = $urandom;
    rxw <= d;
    rxv <= 1'b1;
    @(posedge sys_clk);
    rxv <= 1'b0;
    bus(0, `OFS_RXREG, 0);
    chk("rx word", rd, {23'h0, d});
    $display("reset test done");
    for (s = 0; s < 4; s = s + 1)
    begin
      bus(1, `OFS_MODE, 0);
      pd = s;
      two = s[0];
      alt = (s == 3);
      nb = s ? 9 : 8;
      bus(1, `OFS_MODE, {16'h0, 1'b1, 4'h0, alt, 7'h0, pd, two});
      d = $urandom;
      d[8] = d[8] & alt;
      j = frames;
      send(d, 1);
      repeat (40) @(posedge sys_clk);
      chk("held", frames, j);
      chk("idle", tx_w, 1);
      bus(1, `OFS_STAT, 32'h400);
      repeat (2) @(posedge sys_clk);
      chk("start", tx_w, 0);
      send(d ^ 9'h0a5, 1);
      drain;
    end
    $display("format test done");
    bus(1, `OFS_STAT, 32'h8400);
    send(9'h055, 0);
    send(9'h0aa, 0);
    repeat (6) @(posedge sys_clk);
    bus(1, `OFS_MODE, 32'h0407);
    bus(0, `OFS_STAT, 0);
    chk("stat off", rd, 32'h8110);
    bus(0, `OFS_MODE, 0);
    chk("mode off", rd, 32'h0407);
    repeat (60) @(posedge sys_clk);
    j = frames;
    bus(1, `OFS_MODE, 32'h8407);
    bus(1, `OFS_STAT, 32'h400);
    repeat (80) @(posedge sys_clk);
    chk("flushed", frames, j);
    $display("disable test done");
    for (s = 0; s < 2; s = s + 1)
    begin
      bus(1, `OFS_STAT, s << 15);
      j = ev;
      for (i = 0; i < 5; i = i + 1)
        send($urandom, i < 4);
      bus(0, `OFS_STAT, 0);
      chk("full", rd[9], 1);
      bus(1, `OFS_STAT, (s << 15) | 32'h400);
      drain;
      chk("events", ev - j, s ? 1 : 4);
    end
    $display("buffer test done");
    results;
  end
endmodule // async_serial_setup_transmit_tb_top
